// File: core/clppt_top.sv
// Cascaded long-period pulse timer with AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module clppt_top
  import clppt_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Hardware standby, clears the counters
  input wire logic hw_standby,
  // Capture inputs, index 0 upper, 1 lower
  input wire logic [1:0] capture_a_in,
  input wire logic [1:0] capture_b_in,
  // Pulse outputs
  output logic pulse_output_pin,
  output logic lower_output_pin,
  // AXI4-Lite write address
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Per-channel state, index 0 upper, 1 lower, with the run register and the shared prescaler
  logic [5:0] run_r;
  clppt_ctl_s ctl_r [2];
  logic [3:0] mode_r [2];
  clppt_pin_s pin_r [2];
  logic [15:0] cnt_r [2];
  logic [15:0] ga_r [2];
  logic [15:0] gb_r [2];
  logic [1:0] pin_out_r;
  logic [1:0] cap_a_d_r;
  logic [1:0] cap_b_d_r;
  logic [5:0] psc_r;

  // Bus state
  logic aw_got_r;
  logic w_got_r;
  logic [AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  logic wr_hit;
  logic [7:0] wr_ofs;

  // Event terms
  logic [1:0] run;
  logic [1:0] tick;
  logic [1:0] match_a;
  logic [1:0] match_b;
  logic [1:0] cap_a;
  logic [1:0] cap_b;
  logic [1:0] clr_now;
  logic lower_wrap;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  // Byte-lane merge of an 8-bit register
  function automatic logic [7:0] merge8(input logic [7:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    return s[0] ? d[7:0] : old;
  endfunction

  // Pin action on a compare match
  function automatic logic pin_act(input logic cur, input logic [1:0] code);
    case (code)
      2'b01: return 1'b0;
      2'b10: return 1'b1;
      2'b11: return ~cur;
      default: return cur;
    endcase
  endfunction

  // Offset of a channel register
  function automatic logic [7:0] ch_ofs(input logic [7:0] base, input int c);
    return (c == 0) ? base : base + CH_STRIDE;
  endfunction

  // Internal clock tick for a prescaler code
  function automatic logic psc_tick(input logic [2:0] code,
                                    input logic [5:0] div);
    case (code)
      PSC_DIV1: return 1'b1;
      PSC_DIV4: return &div[1:0];
      PSC_DIV16: return &div[3:0];
      PSC_DIV64: return &div;
      default: return 1'b0;
    endcase
  endfunction

  // Address known to the map
  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= OFS_STATUS);
  endfunction

  // Handshake outputs
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_ofs = 8'(awaddr_r);
  assign wr_hit = wr_go && is_mapped(wr_ofs);

  // Write address and data capture, either order
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_got_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_got_r <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(wr_ofs) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data, one cycle after the address
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(8'(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
      s_axi_rdata <= 32'h0000_0000;
      case (8'(s_axi_araddr))
        OFS_RUN: s_axi_rdata[5:0] <= run_r;
        OFS_UP_CTL: s_axi_rdata[7:0] <= ctl_r[0];
        OFS_UP_MODE: s_axi_rdata[3:0] <= mode_r[0];
        OFS_UP_PIN: s_axi_rdata[7:0] <= pin_r[0];
        OFS_UP_CNT: s_axi_rdata[15:0] <= cnt_r[0];
        OFS_UP_GA: s_axi_rdata[15:0] <= ga_r[0];
        OFS_UP_GB: s_axi_rdata[15:0] <= gb_r[0];
        OFS_LO_CTL: s_axi_rdata[7:0] <= ctl_r[1];
        OFS_LO_MODE: s_axi_rdata[3:0] <= mode_r[1];
        OFS_LO_PIN: s_axi_rdata[7:0] <= pin_r[1];
        OFS_LO_CNT: s_axi_rdata[15:0] <= cnt_r[1];
        OFS_LO_GA: s_axi_rdata[15:0] <= ga_r[1];
        OFS_LO_GB: s_axi_rdata[15:0] <= gb_r[1];
        OFS_STATUS: s_axi_rdata[1:0] <= pin_out_r;
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Run register, one bit per channel
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      run_r <= RUN_RST;
    end else if (wr_hit && wr_ofs == OFS_RUN && wstrb_r[0]) begin
      run_r <= wdata_r[5:0];
    end
  end

  // Mode, control and pin function registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < 2; c++) begin
        ctl_r[c] <= CTL_RST;
        mode_r[c] <= MODE_RST;
        pin_r[c] <= PIN_RST;
      end
    end else if (wr_hit) begin
      for (int c = 0; c < 2; c++) begin
        if (wr_ofs == ch_ofs(OFS_UP_CTL, c))
          ctl_r[c] <= merge8(ctl_r[c], wdata_r, wstrb_r);
        if (wr_ofs == ch_ofs(OFS_UP_MODE, c) && wstrb_r[0])
          mode_r[c] <= wdata_r[3:0];
        if (wr_ofs == ch_ofs(OFS_UP_PIN, c))
          pin_r[c] <= merge8(pin_r[c], wdata_r, wstrb_r);
      end
    end
  end

  // Shared prescaler divider
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      psc_r <= 6'h00;
    end else begin
      psc_r <= psc_r + 6'h01;
    end
  end

  // Capture input edge history
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cap_a_d_r <= 2'b00;
      cap_b_d_r <= 2'b00;
    end else begin
      cap_a_d_r <= capture_a_in;
      cap_b_d_r <= capture_b_in;
    end
  end

  // Lower wrap from maximum to zero drives the upper clock
  assign lower_wrap = tick[1] && cnt_r[1] == CNT_MAX;

  // Count enables, matches, captures and clears
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      run[c] = run_r[c == 0 ? RUN_UPPER : RUN_LOWER];
      tick[c] = run[c] && psc_tick(ctl_r[c].psc, psc_r);
      if (c == 0 && ctl_r[0].psc == PSC_CASCADE)
        tick[c] = run[c] && lower_wrap;
      match_a[c] = tick[c] && !pin_r[c].ioa[3] && cnt_r[c] == ga_r[c];
      match_b[c] = tick[c] && !pin_r[c].iob[3] && cnt_r[c] == gb_r[c];
      cap_a[c] = run[c] && pin_r[c].ioa[3] && capture_a_in[c] && !cap_a_d_r[c];
      cap_b[c] = run[c] && pin_r[c].iob[3] && capture_b_in[c] && !cap_b_d_r[c];
      case (ctl_r[c].clr)
        CLR_ON_A: clr_now[c] = match_a[c] || cap_a[c];
        CLR_ON_B: clr_now[c] = match_b[c] || cap_b[c];
        default: clr_now[c] = 1'b0;
      endcase
    end
  end

  // Channel counters
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < 2; c++) cnt_r[c] <= CNT_RST;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (hw_standby)
          cnt_r[c] <= CNT_RST;
        else if (wr_hit && wr_ofs == ch_ofs(OFS_UP_CNT, c))
          cnt_r[c] <= merge16(cnt_r[c], wdata_r, wstrb_r);
        else if (clr_now[c])
          cnt_r[c] <= CNT_RST;
        else if (tick[c])
          cnt_r[c] <= cnt_r[c] + 16'h0001;
      end
    end
  end

  // Compare and capture registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < 2; c++) begin
        ga_r[c] <= GR_RST;
        gb_r[c] <= GR_RST;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (cap_a[c])
          ga_r[c] <= cnt_r[c];
        else if (wr_hit && wr_ofs == ch_ofs(OFS_UP_GA, c))
          ga_r[c] <= merge16(ga_r[c], wdata_r, wstrb_r);
        if (cap_b[c])
          gb_r[c] <= cnt_r[c];
        else if (wr_hit && wr_ofs == ch_ofs(OFS_UP_GB, c))
          gb_r[c] <= merge16(gb_r[c], wdata_r, wstrb_r);
      end
    end
  end

  // Compare-A pin of each channel
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_out_r <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (!run[c]) begin
          pin_out_r[c] <= pin_r[c].ioa[2];
        end else begin
          case (mode_r[c])
            MODE_PWM1: begin
              if (match_b[c])
                pin_out_r[c] <= pin_act(pin_out_r[c], pin_r[c].iob[1:0]);
              else if (match_a[c])
                pin_out_r[c] <= pin_act(pin_out_r[c], pin_r[c].ioa[1:0]);
            end
            MODE_PWM2: begin
              if (clr_now[c])
                pin_out_r[c] <= pin_r[c].ioa[2];
              else if (match_a[c])
                pin_out_r[c] <= pin_act(pin_out_r[c], pin_r[c].ioa[1:0]);
            end
            MODE_NORMAL: begin
              if (match_a[c])
                pin_out_r[c] <= pin_act(pin_out_r[c], pin_r[c].ioa[1:0]);
            end
            default: pin_out_r[c] <= pin_out_r[c];
          endcase
        end
      end
    end
  end

  // Pin outputs, PWM mode 1 pairs A and B on the A pin
  assign pulse_output_pin = pin_out_r[0];
  assign lower_output_pin = pin_out_r[1];

endmodule
`default_nettype wire

// File: core/clppt_pkg.sv
// Constants and types of the cascaded long-period pulse timer
package clppt_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_RUN = 8'h00;
  localparam logic [7:0] OFS_UP_CTL = 8'h04;
  localparam logic [7:0] OFS_UP_MODE = 8'h08;
  localparam logic [7:0] OFS_UP_PIN = 8'h0C;
  localparam logic [7:0] OFS_UP_CNT = 8'h10;
  localparam logic [7:0] OFS_UP_GA = 8'h14;
  localparam logic [7:0] OFS_UP_GB = 8'h18;
  localparam logic [7:0] OFS_LO_CTL = 8'h1C;
  localparam logic [7:0] OFS_LO_MODE = 8'h20;
  localparam logic [7:0] OFS_LO_PIN = 8'h24;
  localparam logic [7:0] OFS_LO_CNT = 8'h28;
  localparam logic [7:0] OFS_LO_GA = 8'h2C;
  localparam logic [7:0] OFS_LO_GB = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;
  // Byte distance between the two channel register groups
  localparam logic [7:0] CH_STRIDE = 8'h18;

  // Run bit positions of the chained channels
  localparam int RUN_UPPER = 4;
  localparam int RUN_LOWER = 5;

  // Reset values and the counter maximum
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] GR_RST = 16'hFFFF;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [5:0] RUN_RST = 6'h00;

  // Field codes
  localparam logic [2:0] PSC_DIV1 = 3'h0;
  localparam logic [2:0] PSC_DIV4 = 3'h1;
  localparam logic [2:0] PSC_DIV16 = 3'h2;
  localparam logic [2:0] PSC_DIV64 = 3'h3;
  localparam logic [2:0] PSC_CASCADE = 3'h7;
  localparam logic [2:0] CLR_NONE = 3'h0;
  localparam logic [2:0] CLR_ON_A = 3'h1;
  localparam logic [2:0] CLR_ON_B = 3'h2;
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_PWM1 = 4'h2;
  localparam logic [3:0] MODE_PWM2 = 4'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Counter control byte
  typedef struct packed {
    logic [2:0] clr;
    logic [1:0] ckedge;
    logic [2:0] psc;
  } clppt_ctl_s;

  // Pin function byte: bit 3 of a half selects capture, bit 2 the initial
  // level, bits 1:0 the action on match
  typedef struct packed {
    logic [3:0] iob;
    logic [3:0] ioa;
  } clppt_pin_s;

  localparam clppt_ctl_s CTL_RST = 8'h00;
  localparam clppt_pin_s PIN_RST = 8'h00;
  localparam logic [3:0] MODE_RST = 4'h0;

endpackage

// File: bench/clppt_assertions.sv
// Bus handshake and pin checks for the long-period pulse timer
`timescale 1ns/1ns
`default_nettype none
module clppt_checker
  import clppt_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Pins
  input wire logic pulse_output_pin,
  input wire logic lower_output_pin,
  // Write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_pins_reset:
    assert property ($rose(resetn) |-> !pulse_output_pin && !lower_output_pin)
    else $error("pin not at initial level after reset");
  a_bresp_held:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_rdata_held:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_single:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_single:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                     |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_bresp_code:
    assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR)
    else $error("bad write response code");
  a_read_done:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
endmodule

bind clppt_top clppt_checker #(.AW(AW)) clppt_checker_i (
  .clk_sys(clk_sys), .resetn(resetn), .pulse_output_pin(pulse_output_pin),
  .lower_output_pin(lower_output_pin), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// File: bench/clppt_load.sv
// Load model timing the levels seen on the pulse pin
`timescale 1ns/1ns
`default_nettype none
module clppt_load (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Observed pin
  input wire logic pin,
  // Last completed level lengths in clocks
  output logic [31:0] high_len,
  output logic [31:0] low_len
);
  logic pin_r;
  logic [31:0] run_r;

  // Level timer, restarted at each pin edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_r <= 1'h0;
      run_r <= 32'h0;
      high_len <= 32'h0;
      low_len <= 32'h0;
    end else if (pin != pin_r) begin
      pin_r <= pin;
      run_r <= 32'h1;
      if (pin) begin
        low_len <= run_r;
      end else begin
        high_len <= run_r;
      end
    end else begin
      run_r <= run_r + 32'h1;
    end
  end
endmodule
`default_nettype wire

// File: bench/test_clppt.sv
// Self-checking bench for the cascaded long-period pulse timer
`timescale 1ns/1ns
`default_nettype none
module test_cascaded_long_period_pulse_timer;
  import clppt_pkg::*;
  logic clk_sys, resetn, hw_standby, pin_up, pin_lo;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, high_len;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [1:0] cap_a, cap_b;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int n_mismatch = 0;
  int compares = 0;

  // Design and pin load
  clppt_top #(.AW(8)) clppt_top_i (
    .clk_sys(clk_sys), .resetn(resetn), .hw_standby(hw_standby),
    .capture_a_in(cap_a), .capture_b_in(cap_b),
    .pulse_output_pin(pin_up), .lower_output_pin(pin_lo),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  clppt_load clppt_load_i (
    .clk_sys(clk_sys), .resetn(resetn), .pin(pin_up), .high_len(high_len), .low_len());

  // Clock
  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Verdict and stop
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Timeout report
  task automatic give_up;
    n_mismatch++;
    $display("MISMATCH wait expected done seen timeout");
    end_sim();
  endtask

  // Compare one value
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bus write, response taken one cycle after it shows
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      if (bvalid && bready) begin
        break;
      end
      awvalid <= awvalid & ~awready;
      wvalid <= wvalid & ~wready;
      bready <= bvalid;
    end
    check("bresp", {30'h0, bresp}, {30'h0, er});
    bready <= 1'h0;
    if (n == 40) give_up();
  endtask

  // Bus read, data taken one cycle after it shows
  task automatic bus_read(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      if (rvalid && rready) begin
        break;
      end
      arvalid <= arvalid & ~arready;
      rready <= rvalid;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'h0;
    if (n == 40) give_up();
  endtask

  // Read a register and compare it
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
    bus_read(a);
    check($sformatf("reg_%h", a), rd, exp);
    check("rresp", {30'h0, rs}, {30'h0, RESP_OKAY});
  endtask

  // Wait for a pin level
  task automatic wait_pin(input logic lvl, input int limit);
    int n;
    for (n = 0; n < limit; n++) begin
      @(posedge clk_sys);
      if (pin_up === lvl) begin
        break;
      end
    end
    if (n == limit) give_up();
  endtask

  // Reset values and an unmapped read
  task automatic t_reset;
    expect_reg(OFS_RUN, 32'h0);
    expect_reg(OFS_UP_CNT, 32'h0);
    expect_reg(OFS_LO_CNT, 32'h0);
    expect_reg(OFS_UP_GB, {16'h0, GR_RST});
    expect_reg(OFS_UP_MODE, 32'h0);
    check("pin_up", {31'h0, pin_up}, 32'h0);
    bus_read(8'h38);
    check("unmapped", {30'h0, rs}, {30'h0, RESP_SLVERR});
    $display("test reset done");
  endtask

  // Register access, standby and initial pin levels
  task automatic t_regs;
    bus_write(OFS_RUN, 32'h0000000F, RESP_OKAY);
    expect_reg(OFS_RUN, 32'h0000000F);
    bus_write(OFS_UP_GA, 32'h0000A55A, RESP_OKAY);
    expect_reg(OFS_UP_GA, 32'h0000A55A);
    bus_write(OFS_LO_CNT, 32'h00001234, RESP_OKAY);
    expect_reg(OFS_LO_CNT, 32'h00001234);
    hw_standby <= 1'h1;
    @(posedge clk_sys);
    hw_standby <= 1'h0;
    expect_reg(OFS_LO_CNT, 32'h0);
    bus_write(8'h3C, 32'h1, RESP_SLVERR);
    bus_write(OFS_UP_PIN, 32'h00000004, RESP_OKAY);
    bus_write(OFS_LO_PIN, 32'h00000004, RESP_OKAY);
    expect_reg(OFS_STATUS, 32'h00000003);
    check("pin_up_init", {31'h0, pin_up}, 32'h1);
    check("pin_lo_init", {31'h0, pin_lo}, 32'h1);
    bus_write(OFS_LO_PIN, 32'h0, RESP_OKAY);
    bus_write(OFS_RUN, 32'h0, RESP_OKAY);
    $display("test regs done");
  endtask

  // Chained count drives one long pulse
  task automatic t_cascade;
    bus_write(OFS_UP_CTL, {24'h0, CLR_ON_B, 2'h0, PSC_CASCADE}, RESP_OKAY);
    bus_write(OFS_UP_MODE, {28'h0, MODE_PWM1}, RESP_OKAY);
    bus_write(OFS_UP_PIN, 32'h00000052, RESP_OKAY);
    bus_write(OFS_UP_GA, 32'h0, RESP_OKAY);
    bus_write(OFS_UP_GB, 32'h00000001, RESP_OKAY);
    bus_write(OFS_LO_CTL, {24'h0, CLR_NONE, 2'h0, PSC_DIV1}, RESP_OKAY);
    bus_write(OFS_LO_CNT, 32'h0000FFF0, RESP_OKAY);
    bus_write(OFS_RUN, 32'h00000030, RESP_OKAY);
    wait_pin(1'h1, 100);
    expect_reg(OFS_UP_CNT, 32'h1);
    repeat (50) @(posedge clk_sys);
    expect_reg(OFS_UP_CNT, 32'h1);
    wait_pin(1'h0, 70000);
    @(posedge clk_sys);
    check("high_len", high_len, 32'h00010000);
    expect_reg(OFS_UP_CNT, 32'h0);
    bus_write(OFS_RUN, 32'h0, RESP_OKAY);
    $display("test cascade done");
  endtask

  // Count edges at which the lower pin is high
  task automatic count_lo(input int len, output int hi);
    hi = 0;
    repeat (len) begin
      @(posedge clk_sys);
      if (pin_lo === 1'h1) hi++;
    end
  endtask

  // Capture into registers A and B, capture on B clears the count
  task automatic t_capture;
    bus_write(OFS_UP_PIN, 32'h00000088, RESP_OKAY);
    bus_write(OFS_UP_CNT, 32'h00000042, RESP_OKAY);
    bus_write(OFS_RUN, 32'h00000010, RESP_OKAY);
    cap_a <= 2'h1;
    @(posedge clk_sys);
    cap_b <= 2'h1;
    @(posedge clk_sys);
    cap_a <= 2'h0;
    cap_b <= 2'h0;
    expect_reg(OFS_UP_GA, 32'h00000042);
    expect_reg(OFS_UP_GB, 32'h00000042);
    expect_reg(OFS_UP_CNT, 32'h0);
    bus_write(OFS_RUN, 32'h0, RESP_OKAY);
    $display("test capture done");
  endtask

  // Lower channel in PWM mode 2, then in normal toggle mode
  task automatic t_modes;
    int hi;
    bus_write(OFS_LO_CTL, {24'h0, CLR_ON_B, 2'h0, PSC_DIV1}, RESP_OKAY);
    bus_write(OFS_LO_MODE, {28'h0, MODE_PWM2}, RESP_OKAY);
    bus_write(OFS_LO_GA, 32'h00000002, RESP_OKAY);
    bus_write(OFS_LO_GB, 32'h00000005, RESP_OKAY);
    bus_write(OFS_LO_PIN, 32'h00000005, RESP_OKAY);
    bus_write(OFS_LO_CNT, 32'h0, RESP_OKAY);
    check("pin_lo_halt", {31'h0, pin_lo}, 32'h1);
    bus_write(OFS_RUN, 32'h00000020, RESP_OKAY);
    repeat (10) @(posedge clk_sys);
    count_lo(60, hi);
    check("pwm2_high", hi, 32'h1E);
    bus_write(OFS_RUN, 32'h0, RESP_OKAY);
    bus_write(OFS_LO_CTL, {24'h0, CLR_ON_A, 2'h0, PSC_DIV1}, RESP_OKAY);
    bus_write(OFS_LO_MODE, {28'h0, MODE_NORMAL}, RESP_OKAY);
    bus_write(OFS_LO_PIN, 32'h00000003, RESP_OKAY);
    check("pin_lo_low", {31'h0, pin_lo}, 32'h0);
    bus_write(OFS_RUN, 32'h00000020, RESP_OKAY);
    repeat (10) @(posedge clk_sys);
    count_lo(60, hi);
    check("toggle_high", hi, 32'h1E);
    bus_write(OFS_RUN, 32'h0, RESP_OKAY);
    $display("test modes done");
  endtask

  // Main sequence
  initial begin
    resetn = 1'h0;
    hw_standby = 1'h0;
    cap_a = 2'h0;
    cap_b = 2'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    awvalid = 1'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    arvalid = 1'h0;
    rready = 1'h0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'h1;
    t_reset();
    t_regs();
    t_cascade();
    t_capture();
    t_modes();
    end_sim();
  end
endmodule
`default_nettype wire
